//--- rtl/eeac_pkg.sv
// Functional notes
// - Write stores data byte at address
// - Read loads data byte from address
// - Control bits 7..4 read zero
// - Ready irq needs enable and global flag
// - Ready irq is a level while idle
// - Strobe within four cycles of enable writes
// - Strobe without master enable does nothing
// - Master enable self-clears after four cycles
// - Read strobe with valid address reads
// - Read data available right after strobe
// - Read stalls core four cycles
// - Strobe bit clears when programming ends
// - Write start stalls core two cycles
// - Address selects byte 0 to 511
// - No read or address change while busy
package eeac_pkg;

	////////////////////////////////////////////////////////////////
	// I/O locations and control fields
	localparam int          IO_ADDR_W   = 6;
	localparam logic [5:0]  OFS_CTRL    = 6'h1f;
	localparam logic [5:0]  OFS_DATA    = 6'h20;
	localparam logic [5:0]  OFS_ADDR_LO = 6'h21;
	localparam logic [5:0]  OFS_ADDR_HI = 6'h22;
	localparam int          BIT_RIE     = 3;
	localparam int          BIT_MWE     = 2;
	localparam int          BIT_WSTB    = 1;
	localparam int          BIT_RSTB    = 0;
	localparam logic [8:0]  ADDR_RESET  = 9'h000;
	localparam logic [7:0]  DATA_RESET  = 8'h00;

	////////////////////////////////////////////////////////////////
	// Array geometry and timing
	localparam int          MEM_BYTES   = 512;
	localparam int          MEM_ADDR_W  = 9;
	localparam logic [2:0]  MWE_WINDOW  = 3'h4;
	localparam logic [2:0]  READ_STALL  = 3'h4;
	localparam logic [2:0]  WRITE_STALL = 3'h2;
	localparam int          CLK_PERIOD_PS = 5000;
	localparam int          TICK_NS       = 1000;
	localparam int          TICK_CYCLES   = (TICK_NS * 1000) / CLK_PERIOD_PS;
	localparam int          PROG_TIME_US  = 3300;
	localparam int          PROG_TICKS    = (PROG_TIME_US * 1000) / TICK_NS;

	////////////////////////////////////////////////////////////////
	// Core-side I/O request
	typedef struct packed {
		logic [5:0] addr;
		logic       we;
		logic       re;
		logic [7:0] wdata;
	} eeac_io_req_t;

endpackage : eeac_pkg

//--- rtl/eeac_prog_timer.sv
`timescale 1ns/1ps
module eeac_prog_timer #(
	parameter int TICK_CYCLES = eeac_pkg::TICK_CYCLES,
	parameter int PROG_TICKS  = eeac_pkg::PROG_TICKS
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Control
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	import eeac_pkg::*;

	typedef struct packed {
		logic [7:0]  tick_cnt;
		logic [11:0] unit_cnt;
		logic        busy;
	} eeac_tmr_state_t;

	eeac_tmr_state_t st_q;
	eeac_tmr_state_t st_d;
	logic            tick_en;
	logic            last_unit;

	// Microsecond enable keeps the long count narrow
	assign tick_en   = st_q.busy && (st_q.tick_cnt == 8'(TICK_CYCLES - 1));
	assign last_unit = st_q.unit_cnt == 12'(PROG_TICKS - 1);
	assign done      = tick_en && last_unit;
	assign busy      = st_q.busy;

	always_comb begin
		st_d = st_q;
		if (!st_q.busy) begin
			if (start) begin
				st_d.busy     = 1'b1;
				st_d.tick_cnt = 8'h00;
				st_d.unit_cnt = 12'h000;
			end
		end else if (tick_en) begin
			st_d.tick_cnt = 8'h00;
			if (last_unit) begin
				st_d.busy = 1'b0;
			end else begin
				st_d.unit_cnt = st_q.unit_cnt + 12'h001;
			end
		end else begin
			st_d.tick_cnt = st_q.tick_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

endmodule : eeac_prog_timer

//--- rtl/eeac_top.sv
`timescale 1ns/1ps
module eeac_top #(
	parameter int TICK_CYCLES = eeac_pkg::TICK_CYCLES,
	parameter int PROG_TICKS  = eeac_pkg::PROG_TICKS
) (
	// Clock and reset
	input  wire logic                  CLOCK,
	input  wire logic                  RST,
	// Core I/O register access
	input  wire eeac_pkg::eeac_io_req_t IO_REQ,
	output logic [7:0]                 IO_RDATA,
	// Core status and control
	input  wire logic                  GLOBAL_IRQ_ENABLE,
	output logic                       READY_IRQ,
	output logic                       CPU_STALL
);
	import eeac_pkg::*;

	typedef struct packed {
		logic [8:0] addr_q;
		logic [7:0] data_q;
		logic       rie_q;
		logic [2:0] mwe_cnt_q;
		logic [2:0] stall_cnt_q;
		logic [7:0] rdata_q;
		logic [8:0] lat_addr_q;
		logic [7:0] lat_data_q;
	} eeac_state_t;

	eeac_state_t st_q;
	eeac_state_t st_d;

	logic [7:0] mem [MEM_BYTES];

	logic       busy;
	logic       done;
	logic       mwe;
	logic       ctrl_wr;
	logic       wstb_req;
	logic       rstb_req;
	logic       mwe_set;
	logic       write_start;
	logic       read_go;
	logic [7:0] rd_byte;
	logic [7:0] ctrl_view;

	////////////////////////////////////////////////////////////////
	// Request decode

	assign ctrl_wr     = IO_REQ.we && (IO_REQ.addr == OFS_CTRL);
	assign wstb_req    = ctrl_wr && IO_REQ.wdata[BIT_WSTB];
	assign rstb_req    = ctrl_wr && IO_REQ.wdata[BIT_RSTB];
	assign mwe_set     = ctrl_wr && IO_REQ.wdata[BIT_MWE];
	assign mwe         = st_q.mwe_cnt_q != 3'h0;
	// Enable must already be open; same-write enable does not count
	assign write_start = wstb_req && mwe && !busy;
	assign read_go     = rstb_req && !busy;
	assign rd_byte     = mem[st_q.addr_q];

	// Strobe bit shows the programming timer, cleared by its end
	assign ctrl_view = {4'h0, st_q.rie_q, mwe, busy, 1'b0};

	////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_d = st_q;

		// Master enable window
		if (mwe_set) begin
			st_d.mwe_cnt_q = MWE_WINDOW;
		end else if (mwe) begin
			st_d.mwe_cnt_q = st_q.mwe_cnt_q - 3'h1;
		end

		if (st_q.stall_cnt_q != 3'h0) begin
			st_d.stall_cnt_q = st_q.stall_cnt_q - 3'h1;
		end

		if (IO_REQ.we) begin
			unique case (IO_REQ.addr)
				OFS_CTRL: begin
					st_d.rie_q = IO_REQ.wdata[BIT_RIE];
				end
				OFS_DATA: begin
					st_d.data_q = IO_REQ.wdata;
				end
				OFS_ADDR_LO: begin
					if (!busy) begin
						st_d.addr_q[7:0] = IO_REQ.wdata;
					end
				end
				OFS_ADDR_HI: begin
					if (!busy) begin
						st_d.addr_q[8] = IO_REQ.wdata[0];
					end
				end
				default: begin
				end
			endcase
		end

		// Latch the byte so later data writes cannot corrupt it
		if (write_start) begin
			st_d.lat_addr_q  = st_q.addr_q;
			st_d.lat_data_q  = st_q.data_q;
			st_d.stall_cnt_q = WRITE_STALL;
		end

		if (read_go) begin
			st_d.data_q      = rd_byte;
			st_d.stall_cnt_q = READ_STALL;
		end

		if (IO_REQ.re) begin
			unique case (IO_REQ.addr)
				OFS_CTRL:    st_d.rdata_q = ctrl_view;
				OFS_DATA:    st_d.rdata_q = st_q.data_q;
				OFS_ADDR_LO: st_d.rdata_q = st_q.addr_q[7:0];
				OFS_ADDR_HI: st_d.rdata_q = {7'h00, st_q.addr_q[8]};
				default:     st_d.rdata_q = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			st_q <= '{addr_q: ADDR_RESET, data_q: DATA_RESET, default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Array; the cell is committed when the programming time ends

	always_ff @(posedge CLOCK) begin
		if (done) begin
			mem[st_q.lat_addr_q] <= st_q.lat_data_q;
		end
	end

	eeac_prog_timer #(
		.TICK_CYCLES (TICK_CYCLES),
		.PROG_TICKS  (PROG_TICKS)
	) u_timer (
		.clk   (CLOCK),
		.rst   (RST),
		.start (write_start),
		.busy  (busy),
		.done  (done)
	);

	////////////////////////////////////////////////////////////////
	// Outputs

	assign IO_RDATA  = st_q.rdata_q;
	assign CPU_STALL = st_q.stall_cnt_q != 3'h0;
	// Level, not a pulse: stays up the whole time the array is idle
	assign READY_IRQ = st_q.rie_q && GLOBAL_IRQ_ENABLE && !busy;

	////////////////////////////////////////////////////////////////
	// Checks

	a_reserved_zero: assert property (
		@(posedge CLOCK) disable iff (RST)
		(IO_REQ.re && IO_REQ.addr == OFS_CTRL) |=> (IO_RDATA[7:4] == 4'h0 && !IO_RDATA[0]))
		else $error("Reserved control bits read nonzero");

	a_irq_gate: assert property (
		@(posedge CLOCK) disable iff (RST)
		(!GLOBAL_IRQ_ENABLE || !st_q.rie_q) |-> !READY_IRQ)
		else $error("Ready interrupt raised while disabled");

	// Only a control write, a new write start or a dropped global flag may take the request away
	a_irq_level: assert property (
		@(posedge CLOCK) disable iff (RST)
		(READY_IRQ && !ctrl_wr && !write_start) |=> (READY_IRQ || !GLOBAL_IRQ_ENABLE))
		else $error("Ready interrupt not held as a level");

	a_mwe_timeout: assert property (
		@(posedge CLOCK) disable iff (RST)
		(mwe_set ##1 !mwe_set[*4]) |=> !mwe)
		else $error("Master enable did not clear after four cycles");

	a_mwe_window: assert property (
		@(posedge CLOCK) disable iff (RST)
		mwe_set |=> mwe[*4])
		else $error("Master enable window shorter than four cycles");

	a_write_gated: assert property (
		@(posedge CLOCK) disable iff (RST)
		(wstb_req && !mwe && !busy) |=> !busy)
		else $error("Write started without master enable");

	a_write_stall: assert property (
		@(posedge CLOCK) disable iff (RST)
		(write_start && !rstb_req) |=> (busy && CPU_STALL) ##1 CPU_STALL ##1 !CPU_STALL)
		else $error("Write stall not two cycles");

	a_read_stall: assert property (
		@(posedge CLOCK) disable iff (RST)
		(read_go && !wstb_req) |=> CPU_STALL[*4] ##1 !CPU_STALL)
		else $error("Read stall not four cycles");

	a_read_data: assert property (
		@(posedge CLOCK) disable iff (RST)
		read_go |=> (st_q.data_q == $past(rd_byte)))
		else $error("Read did not load the addressed byte");

	a_addr_locked: assert property (
		@(posedge CLOCK) disable iff (RST)
		(busy && $past(busy)) |-> $stable(st_q.addr_q))
		else $error("Address changed during a write");

	a_busy_release: assert property (
		@(posedge CLOCK) disable iff (RST)
		done |=> (!busy && !ctrl_view[BIT_WSTB]))
		else $error("Strobe bit not cleared at end of write");

	a_busy_hold: assert property (
		@(posedge CLOCK) disable iff (RST)
		(busy && wstb_req && !done) |=> (busy && $stable(st_q.lat_addr_q) && $stable(st_q.lat_data_q)))
		else $error("Strobe accepted while a write was busy");

	a_rdata_hold: assert property (
		@(posedge CLOCK) disable iff (RST)
		!IO_REQ.re |=> $stable(IO_RDATA))
		else $error("Read data changed without a read");

	a_write_commit: assert property (
		@(posedge CLOCK) disable iff (RST)
		done |=> (mem[$past(st_q.lat_addr_q)] == $past(st_q.lat_data_q)))
		else $error("Latched byte not committed to the array");

	// A refused strobe must not halt the core
	a_strobe_refused: assert property (
		@(posedge CLOCK) disable iff (RST)
		(wstb_req && !mwe && !rstb_req && !CPU_STALL) |=> !CPU_STALL)
		else $error("Strobe without master enable stalled the core");

	a_read_refused: assert property (
		@(posedge CLOCK) disable iff (RST)
		(busy && rstb_req && !CPU_STALL) |=> !CPU_STALL)
		else $error("Read performed during a write");

	a_addr_high_zero: assert property (
		@(posedge CLOCK) disable iff (RST)
		(IO_REQ.re && IO_REQ.addr == OFS_ADDR_HI) |=> (IO_RDATA[7:1] == 7'h00))
		else $error("Address high byte reads above bit 8");

endmodule : eeac_top

//--- test/eeac_core_model.sv
`timescale 1ns/1ps
////////////////////////////////////////
module eeac_core_model (
	// Core side of the I/O bus
	input  wire logic              clk,
	output eeac_pkg::eeac_io_req_t req,
	input  wire logic [7:0]        rdata,
	input  wire logic              stall
);
	import eeac_pkg::*;
	initial req = '0;
	// A halted core issues nothing, so wait out the stall first
	task automatic xfer(input logic [5:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		while (stall === 1'b1) @(posedge clk);
		req <= '{addr: a, we: w, re: !w, wdata: d};
		@(posedge clk);
		req.we <= 1'b0;
		req.re <= 1'b0;
		if (!w) begin
			@(posedge clk);
			q = rdata;
		end
	endtask : xfer
endmodule : eeac_core_model

//--- test/eeac_top_test.sv
`timescale 1ns/1ps
////////////////////////////////////////
module eeac_top_test;
	import eeac_pkg::*;
	typedef struct packed { logic [8:0] a; logic [7:0] d; } eeac_row_t;
	logic         CLOCK = 1'b0;
	logic         RST   = 1'b1;
	logic         gie   = 1'b0;
	eeac_io_req_t io_req;
	logic [7:0]   io_rdata;
	logic         ready_irq;
	logic         cpu_stall;
	logic [7:0]   q;
	int           err_count = 0;
	int           comparisons = 0;
	int           cyc = 0;
	int           stall_n = 0;
	eeac_row_t    rows [4] = '{'{9'h000, 8'ha5}, '{9'h1ff, 8'h5a}, '{9'h100, 8'h3c}, '{9'h0ff, 8'hc3}};

	eeac_top #(.TICK_CYCLES(2), .PROG_TICKS(10)) u_eeac_top (.CLOCK(CLOCK), .RST(RST), .IO_REQ(io_req),
		.IO_RDATA(io_rdata), .GLOBAL_IRQ_ENABLE(gie), .READY_IRQ(ready_irq), .CPU_STALL(cpu_stall));
	eeac_core_model u_eeac_core_model (.clk(CLOCK), .req(io_req), .rdata(io_rdata), .stall(cpu_stall));

	always #2.5 CLOCK = ~CLOCK;
	// Ceiling well above the few hundred cycles the run needs
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
		if (cpu_stall === 1'b1) stall_n <= stall_n + 1;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end

	////////////////////////////////////////
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		u_eeac_core_model.xfer(a, 1'b1, d, q);
	endtask : wr
	task automatic rd(input logic [5:0] a);
		u_eeac_core_model.xfer(a, 1'b0, 8'h00, q);
	endtask : rd
	task automatic set_addr(input logic [8:0] a);
		wr(OFS_ADDR_LO, a[7:0]);
		wr(OFS_ADDR_HI, {7'h00, a[8]});
	endtask : set_addr
	task automatic wait_idle;
		for (int k = 0; k < 40; k++) begin
			rd(OFS_CTRL);
			if (q[BIT_WSTB] === 1'b0) break;
		end
		chk("idle", {7'h00, q[BIT_WSTB]}, 8'h00);
	endtask : wait_idle
	// Ready enable kept as given in bit 3 of c
	task automatic prog(input logic [8:0] a, input logic [7:0] d, input logic [7:0] c);
		set_addr(a);
		wr(OFS_DATA, d);
		wr(OFS_CTRL, c | 8'h04);
		wr(OFS_CTRL, c | 8'h02);
	endtask : prog
	task automatic fetch(input logic [8:0] a);
		set_addr(a);
		wr(OFS_CTRL, 8'h01);
		rd(OFS_DATA);
	endtask : fetch
	task automatic print_verdict;
		$display("checks %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	////////////////////////////////////////
	initial begin
		repeat (16) @(posedge CLOCK);
		chk("rdata rst", io_rdata, 8'h00);
		RST <= 1'b0;
		rd(OFS_CTRL);
		chk("ctrl rst", q, 8'h00);
		rd(OFS_DATA);
		chk("data rst", q, DATA_RESET);
		foreach (rows[r]) begin
			prog(rows[r].a, rows[r].d, 8'h00);
			wait_idle();
			stall_n = 0;
			fetch(rows[r].a);
			chk("readback", q, rows[r].d);
			chk("rd stall", 8'(stall_n), 8'h04);
		end
		// Strobe with no master enable, then with an expired one
		set_addr(9'h000);
		wr(OFS_DATA, 8'h11);
		wr(OFS_CTRL, 8'h02);
		rd(OFS_CTRL);
		chk("no mwe", q, 8'h00);
		wr(OFS_CTRL, 8'h04);
		rd(OFS_CTRL);
		chk("mwe set", q, 8'h04);
		// Strobe lands on the fifth cycle after the enable, one past the window
		wr(OFS_CTRL, 8'h02);
		rd(OFS_CTRL);
		chk("mwe gone", q, 8'h00);
		fetch(9'h000);
		chk("unwritten", q, 8'ha5);
		// Strobe on the fourth cycle, the last one still open
		wr(OFS_CTRL, 8'h04);
		wr(OFS_DATA, 8'h5c);
		wr(OFS_CTRL, 8'h02);
		wait_idle();
		fetch(9'h000);
		chk("last slot", q, 8'h5c);
		// Address, read and write strobe requests while busy are dropped
		stall_n = 0;
		prog(9'h0ff, 8'h77, 8'h00);
		rd(OFS_CTRL);
		chk("busy", q, 8'h02);
		chk("wr stall", 8'(stall_n), 8'h02);
		stall_n = 0;
		wr(OFS_ADDR_LO, 8'h00);
		wr(OFS_CTRL, 8'h01);
		wr(OFS_CTRL, 8'h04);
		wr(OFS_CTRL, 8'h02);
		chk("busy stall", 8'(stall_n), 8'h00);
		wait_idle();
		chk("done", q, 8'h00);
		wr(OFS_CTRL, 8'h01);
		rd(OFS_DATA);
		chk("addr held", q, 8'h77);
		rd(OFS_ADDR_LO);
		chk("addr lo", q, 8'hff);
		rd(OFS_ADDR_HI);
		chk("addr hi", q, 8'h00);
		// Ready request gated by enable, global flag and busy
		wr(OFS_CTRL, 8'h08);
		@(posedge CLOCK);
		chk("irq gie0", {7'h00, ready_irq}, 8'h00);
		gie <= 1'b1;
		@(posedge CLOCK);
		@(posedge CLOCK);
		chk("irq on", {7'h00, ready_irq}, 8'h01);
		prog(9'h010, 8'h99, 8'h08);
		@(posedge CLOCK);
		chk("irq busy", {7'h00, ready_irq}, 8'h00);
		wait_idle();
		repeat (3) @(posedge CLOCK);
		chk("irq level", {7'h00, ready_irq}, 8'h01);
		wr(OFS_CTRL, 8'h00);
		@(posedge CLOCK);
		chk("irq off", {7'h00, ready_irq}, 8'h00);
		fetch(9'h010);
		chk("rb irq", q, 8'h99);
		// Second reset mid-run
		wr(OFS_CTRL, 8'h08);
		RST <= 1'b1;
		repeat (2) @(posedge CLOCK);
		RST <= 1'b0;
		rd(OFS_CTRL);
		chk("ctrl rst2", q, 8'h00);
		print_verdict();
	end
endmodule : eeac_top_test
